// File: core/bil_boot_loader.sv
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// RL1: serial boot enables select, clock and data pins and samples on rising clock, modes 0/0 and 1/1.
// RL2: serial bytes arrive least significant bit first and are assembled in that order.
// RL3: link boot enables the link about 2 us after boot starts.
// RL4: enabling the link drops its pull resistors, drives transmit wires low and watches receive wires.
// RL5: the partner holds the receive wires low when the link is enabled.
// RL6: the first link word names the acknowledge channel, 0x0000FF02 meaning no acknowledge.
// RL7: the image then arrives in order, closed by an END control token.
// RL8: after the image an END goes to the acknowledge channel, channel-end 0 is freed, then the jump.
// RL9: secure boot reads the image from one-time memory starting at address 0.
// RL10: pull resistors are on during and after reset, off when the pin is enabled, then software's.
// RL11: one boot source is latched after reset and held until boot completes.
module bil_boot_loader #(
    parameter int OTP_AW = 12,
    parameter int OTP_IMG_BYTES = 64,
    parameter int FIFO_DEPTH = 8
) (
    input wire logic core_clk, // tile clock
    input wire logic rst_n, // sync reset, low
    input wire logic [1:0] boot_mode, // boot strap pins
    input wire logic spi_ss_n, // serial select, low
    input wire logic spi_sclk, // serial clock from master
    input wire logic spi_mosi, // serial data in
    input wire logic link_rx_clk, // link receive clock
    input wire logic link_rx_data, // link receive data
    output logic link_tx_clk, // link transmit clock
    output logic link_tx_data, // link transmit data
    output logic link_tx_oe, // link wires driven
    output logic link_en, // link enabled
    output logic spi_pin_en, // serial pins enabled
    output logic [1:0] weak_pull_resistor_en, // [0] serial pins, [1] link pins
    input wire logic pull_sw_we, // software pull update
    input wire logic [1:0] pull_sw_val, // software pull value
    output logic otp_rd_en, // one-time memory read pulse
    output logic [OTP_AW-1:0] otp_addr, // one-time memory address
    input wire logic [7:0] otp_rdata, // one-time memory data
    input wire logic otp_rvalid, // read data valid
    output logic img_valid, // image byte ready
    output logic [7:0] img_data, // image byte
    input wire logic img_ready, // loader sink takes byte
    output logic [1:0] boot_src, // latched source
    output logic boot_busy, // boot in progress
    output logic chanend0_alloc, // channel-end 0 held
    output logic jump, // jump to loaded code, pulse
    output logic overflow // byte lost, sticky
);
    localparam logic [OTP_AW:0] OTP_END = (OTP_AW + 1)'(OTP_IMG_BYTES);
    localparam int PW = 7;

    bil_pkg::bil_state_e state_q;
    logic [PW-1:0] s1_q, s2_q, s3_q, f_q, fp_q;
    bil_pkg::bil_pins_s f, fp;
    logic [2:0] settle_q;
    logic [7:0] dly_q;
    logic [1:0] bcnt_q;
    logic [31:0] ack_q;
    logic [7:0] ssh_q;
    logic [2:0] sbit_q;
    logic [8:0] lsh_q;
    logic [3:0] lbit_q;
    logic sym_done_q;
    bil_pkg::bil_sym_s sym_q;
    logic push_q;
    logic [7:0] push_data_q;
    logic fifo_in_ready;
    logic otp_pend_q;
    logic [OTP_AW:0] otp_cnt_q;
    logic [3:0] tx_div_q;
    logic [3:0] tx_bit_q;
    logic [1:0] tx_sym_q;
    logic [8:0] tx_sh_q;
    logic tx_act_q, tx_done_q;
    logic [1:0] en_prev_q;
    logic jumped_q;
    logic spi_byte, link_end, link_data;
    logic [8:0] first_sym;
    logic [8:0] next_sym;

    assign f = bil_pkg::bil_pins_s'(f_q);
    assign fp = bil_pkg::bil_pins_s'(fp_q);
    assign spi_byte = state_q == bil_pkg::ST_RECV && boot_src == bil_pkg::MODE_SPI
        && !f.ss_n && f.sclk && !fp.sclk; // rising edge for both supported modes [RL1]
    assign link_end = sym_done_q && sym_q.ctrl && sym_q.data == bil_pkg::END_TOKEN;
    assign link_data = sym_done_q && !sym_q.ctrl;

    // symbol sent to the acknowledge channel: three header bytes then END
    function automatic logic [8:0] ack_sym(input logic [1:0] idx, input logic [31:0] ch);
        logic [8:0] s;
        s = {1'b0, ch[31:24]};
        if (idx == 2'h1) begin
            s = {1'b0, ch[23:16]};
        end else if (idx == 2'h2) begin
            s = {1'b0, ch[15:8]};
        end else if (idx == 2'h3) begin
            s = {1'b1, bil_pkg::END_TOKEN};
        end
        return s;
    endfunction

    // first and following acknowledge symbols, bit 0 goes out first
    assign first_sym = ack_sym(2'h0, ack_q);
    assign next_sym = ack_sym(tx_sym_q + 2'h1, ack_q);

    // pin synchronisers; a change counts once stages two and three agree
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            s1_q <= bil_pkg::PINS_RST;
            s2_q <= bil_pkg::PINS_RST;
            s3_q <= bil_pkg::PINS_RST;
            f_q <= bil_pkg::PINS_RST;
            fp_q <= bil_pkg::PINS_RST;
        end else begin
            s1_q <= {boot_mode, spi_ss_n, spi_sclk, spi_mosi, link_rx_clk, link_rx_data};
            s2_q <= s1_q;
            s3_q <= s2_q;
            f_q <= (s3_q & ~(s2_q ^ s3_q)) | (f_q & (s2_q ^ s3_q));
            fp_q <= f_q;
        end
    end

    // boot sequencer; the strap is caught after release once the filter settles
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            state_q <= bil_pkg::ST_IDLE;
            boot_src <= bil_pkg::MODE_NONE;
            settle_q <= '0;
            dly_q <= '0;
            bcnt_q <= '0;
            ack_q <= '0;
            boot_busy <= 1'b0;
            spi_pin_en <= 1'b0;
            link_en <= 1'b0;
            chanend0_alloc <= 1'b0;
        end else begin
            case (state_q)
                bil_pkg::ST_IDLE: begin
                    if (settle_q != 3'(bil_pkg::SETTLE_CYC)) begin
                        settle_q <= settle_q + 1'b1;
                    end else if (f.boot_mode != bil_pkg::MODE_NONE) begin
                        boot_src <= f.boot_mode; // latched once, held to the end [RL11]
                        boot_busy <= 1'b1;
                        dly_q <= '0;
                        if (f.boot_mode == bil_pkg::MODE_LINK) begin
                            state_q <= bil_pkg::ST_LWAIT;
                        end else begin
                            spi_pin_en <= (f.boot_mode == bil_pkg::MODE_SPI); // [RL1]
                            state_q <= bil_pkg::ST_RECV;
                        end
                    end
                end
                bil_pkg::ST_LWAIT: begin
                    dly_q <= dly_q + 1'b1;
                    if (dly_q == 8'(bil_pkg::LINK_EN_CYC - 1)) begin
                        link_en <= 1'b1; // link up after the start delay [RL3]
                        chanend0_alloc <= 1'b1;
                        bcnt_q <= '0;
                        state_q <= bil_pkg::ST_ACKW;
                    end
                end
                bil_pkg::ST_ACKW: begin
                    if (link_data) begin
                        ack_q <= {ack_q[23:0], sym_q.data}; // word arrives high byte first [RL6]
                        bcnt_q <= bcnt_q + 1'b1;
                        if (bcnt_q == 2'h3) begin
                            state_q <= bil_pkg::ST_RECV;
                        end
                    end
                end
                bil_pkg::ST_RECV: begin
                    if (boot_src == bil_pkg::MODE_SPI && f.ss_n && !fp.ss_n) begin
                        state_q <= bil_pkg::ST_DONE;
                    end else if (boot_src == bil_pkg::MODE_LINK && link_end) begin
                        if (ack_q == bil_pkg::ACK_NULL) begin
                            chanend0_alloc <= 1'b0; // no acknowledge wanted [RL6]
                            state_q <= bil_pkg::ST_DONE;
                        end else begin
                            state_q <= bil_pkg::ST_SEND; // image closed by END [RL7]
                        end
                    end else if (boot_src == bil_pkg::MODE_OTP && otp_cnt_q == OTP_END
                                 && !otp_pend_q && !push_q) begin
                        state_q <= bil_pkg::ST_DONE;
                    end
                end
                bil_pkg::ST_SEND: begin
                    if (tx_done_q) begin
                        chanend0_alloc <= 1'b0; // freed only after END is out [RL8]
                        state_q <= bil_pkg::ST_DONE;
                    end
                end
                bil_pkg::ST_DONE: begin
                    if (jumped_q) begin
                        boot_busy <= 1'b0;
                    end
                end
                default: begin
                    state_q <= bil_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // serial slave byte assembly, lsb first; select high restarts framing
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            ssh_q <= '0;
            sbit_q <= '0;
        end else if (f.ss_n) begin
            sbit_q <= '0;
        end else if (spi_byte) begin
            ssh_q <= {f.mosi, ssh_q[7:1]}; // first bit ends in bit 0 [RL2]
            sbit_q <= sbit_q + 1'b1;
        end
    end

    // link symbol receiver: eight data bits lsb first, then the control flag
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            lsh_q <= '0;
            lbit_q <= '0;
            sym_done_q <= 1'b0;
            sym_q <= '0;
        end else begin
            sym_done_q <= 1'b0;
            if (link_en && f.lrx_clk && !fp.lrx_clk) begin // receive wires watched [RL4]
                lsh_q <= {f.lrx_data, lsh_q[8:1]};
                lbit_q <= (lbit_q == 4'(bil_pkg::SYM_BITS - 1)) ? '0 : lbit_q + 1'b1;
                if (lbit_q == 4'(bil_pkg::SYM_BITS - 1)) begin
                    sym_done_q <= 1'b1;
                    sym_q <= bil_pkg::bil_sym_s'({f.lrx_data, lsh_q[8:1]});
                end
            end
        end
    end

    // one-time memory fetch, one byte in flight, stalls on a full buffer
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            otp_rd_en <= 1'b0;
            otp_addr <= OTP_AW'(bil_pkg::OTP_START_ADDR);
            otp_pend_q <= 1'b0;
            otp_cnt_q <= '0;
        end else begin
            otp_rd_en <= 1'b0;
            if (otp_pend_q && otp_rvalid) begin
                otp_pend_q <= 1'b0;
                otp_cnt_q <= otp_cnt_q + 1'b1;
            end else if (state_q == bil_pkg::ST_RECV && boot_src == bil_pkg::MODE_OTP
                         && !otp_pend_q && !push_q && fifo_in_ready && otp_cnt_q != OTP_END) begin
                otp_rd_en <= 1'b1;
                otp_addr <= otp_cnt_q[OTP_AW-1:0]; // counts up from address 0 [RL9]
                otp_pend_q <= 1'b1;
            end
        end
    end

    // image bytes into the buffer; serial and link cannot be held off, so losses stick
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            push_q <= 1'b0;
            push_data_q <= '0;
            overflow <= 1'b0;
        end else begin
            push_q <= 1'b0;
            if (spi_byte && sbit_q == 3'h7) begin
                push_q <= 1'b1;
                push_data_q <= {f.mosi, ssh_q[7:1]}; // [RL2]
            end else if (state_q == bil_pkg::ST_RECV && boot_src == bil_pkg::MODE_LINK
                         && link_data) begin
                push_q <= 1'b1;
                push_data_q <= sym_q.data; // image bytes kept in arrival order [RL7]
            end else if (otp_pend_q && otp_rvalid) begin
                push_q <= 1'b1;
                push_data_q <= otp_rdata;
            end
            if (push_q && !fifo_in_ready) begin
                overflow <= 1'b1;
            end
        end
    end

    // link transmitter; wires sit low from enable, data moves on the falling half
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            link_tx_clk <= 1'b0;
            link_tx_data <= 1'b0;
            link_tx_oe <= 1'b0;
            tx_div_q <= '0;
            tx_bit_q <= '0;
            tx_sym_q <= '0;
            tx_sh_q <= '0;
            tx_act_q <= 1'b0;
            tx_done_q <= 1'b0;
        end else begin
            tx_done_q <= 1'b0;
            link_tx_oe <= link_en; // driven low as initial state [RL4]
            if (state_q == bil_pkg::ST_SEND && !tx_act_q && !tx_done_q) begin
                tx_act_q <= 1'b1;
                tx_sym_q <= '0;
                tx_bit_q <= '0;
                tx_sh_q <= first_sym;
                link_tx_data <= first_sym[0];
                tx_div_q <= '0;
            end else if (tx_act_q) begin
                tx_div_q <= (tx_div_q == 4'(bil_pkg::TX_HALF_CYC - 1)) ? '0 : tx_div_q + 1'b1;
                if (tx_div_q == 4'(bil_pkg::TX_HALF_CYC - 1)) begin
                    link_tx_clk <= !link_tx_clk;
                    if (link_tx_clk) begin
                        if (tx_bit_q != 4'(bil_pkg::SYM_BITS - 1)) begin
                            tx_bit_q <= tx_bit_q + 1'b1;
                            tx_sh_q <= {1'b0, tx_sh_q[8:1]};
                            link_tx_data <= tx_sh_q[1];
                        end else if (tx_sym_q == 2'h3) begin
                            tx_act_q <= 1'b0;
                            tx_done_q <= 1'b1; // END token fully sent [RL8]
                            link_tx_data <= 1'b0;
                        end else begin
                            tx_sym_q <= tx_sym_q + 1'b1;
                            tx_bit_q <= '0;
                            tx_sh_q <= next_sym;
                            link_tx_data <= next_sym[0];
                        end
                    end
                end
            end
        end
    end

    // pull resistors on from reset, dropped as each pin group is enabled
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            weak_pull_resistor_en <= bil_pkg::PULL_RST; // [RL10]
            en_prev_q <= '0;
        end else begin
            en_prev_q <= {link_en, spi_pin_en};
            if (spi_pin_en && !en_prev_q[0]) begin
                weak_pull_resistor_en[bil_pkg::PULL_SPI] <= 1'b0; // [RL1] [RL10]
            end else if (link_en && !en_prev_q[1]) begin
                weak_pull_resistor_en[bil_pkg::PULL_LINK] <= 1'b0; // [RL4] [RL10]
            end else if (pull_sw_we && state_q == bil_pkg::ST_DONE) begin
                weak_pull_resistor_en <= pull_sw_val; // software owns them afterwards [RL10]
            end
        end
    end

    // jump once the buffer has drained into the loader sink
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            jump <= 1'b0;
            jumped_q <= 1'b0;
        end else begin
            jump <= 1'b0;
            if (state_q == bil_pkg::ST_DONE && !img_valid && !jumped_q && !chanend0_alloc) begin
                jump <= 1'b1; // [RL8]
                jumped_q <= 1'b1;
            end
        end
    end

    bil_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .in_valid(push_q),
        .in_ready(fifo_in_ready),
        .in_data(push_data_q),
        .out_valid(img_valid),
        .out_ready(img_ready),
        .out_data(img_data)
    );

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    a_spi_pins_on: assert property (state_q == bil_pkg::ST_RECV && boot_src == bil_pkg::MODE_SPI
        |-> spi_pin_en && !weak_pull_resistor_en[0] || $rose(spi_pin_en)) // [RL1]
        else $error("serial pins not enabled in serial boot");
    a_spi_lsb_first: assert property (push_q && boot_src == bil_pkg::MODE_SPI
        |-> push_data_q[7] == $past(f.mosi)) // [RL2]
        else $error("serial byte not assembled lsb first");
    a_link_delay: assert property ($rose(link_en) |-> $past(dly_q) == 8'(bil_pkg::LINK_EN_CYC - 1)
        && $past(state_q) == bil_pkg::ST_LWAIT) // [RL3]
        else $error("link enabled at the wrong time");
    a_link_init_low: assert property ($rose(link_en) |=> link_tx_oe && !link_tx_data
        && !link_tx_clk && !weak_pull_resistor_en[1]) // [RL4]
        else $error("link not in initial low state");
    a_null_no_ack: assert property (state_q == bil_pkg::ST_SEND |-> ack_q != bil_pkg::ACK_NULL) // [RL6]
        else $error("acknowledge sent to null channel");
    a_end_closes: assert property (state_q == bil_pkg::ST_RECV && boot_src == bil_pkg::MODE_LINK
        && link_end |=> state_q inside {bil_pkg::ST_SEND, bil_pkg::ST_DONE}) // [RL7]
        else $error("END token did not close image");
    a_jump_after_free: assert property (jump |-> !chanend0_alloc
        && state_q == bil_pkg::ST_DONE) // [RL8]
        else $error("jump before channel-end freed");
    a_otp_from_zero: assert property (otp_rd_en && $past(otp_cnt_q) == '0
        |-> otp_addr == OTP_AW'(bil_pkg::OTP_START_ADDR)) // [RL9]
        else $error("one-time read not from address 0");
    a_pull_held: assert property (!spi_pin_en && !link_en && state_q != bil_pkg::ST_DONE
        |-> weak_pull_resistor_en == bil_pkg::PULL_RST) // [RL10]
        else $error("pull resistor dropped early");
    a_src_stable: assert property (state_q != bil_pkg::ST_IDLE
        && $past(state_q) != bil_pkg::ST_IDLE |-> $stable(boot_src)) // [RL11]
        else $error("boot source changed during boot");
endmodule
`default_nettype wire

// File: core/bil_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module bil_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input wire logic core_clk, // core clock
    input wire logic rst_n, // sync reset, low
    input wire logic in_valid, // write request
    output logic in_ready, // room for a word
    input wire logic [WIDTH-1:0] in_data, // word in
    output logic out_valid, // word waiting
    input wire logic out_ready, // reader takes word
    output logic [WIDTH-1:0] out_data // oldest word
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic [AW:0] cnt_q;
    logic do_wr;
    logic do_rd;

    // flags straight from the occupancy count
    assign in_ready = (cnt_q < (AW + 1)'(DEPTH)); // room until the count reaches depth
    assign out_valid = (cnt_q != '0);
    assign out_data = mem[rd_q];
    assign do_wr = in_valid && in_ready;
    assign do_rd = out_valid && out_ready;

    // storage, no reset needed on data
    always_ff @(posedge core_clk) begin
        if (do_wr) begin
            mem[wr_q] <= in_data;
        end
    end

    // pointers wrap at depth, which need not be a power of two
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end else begin
            if (do_wr) begin
                wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
            end
            if (do_rd) begin
                rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
            end
            cnt_q <= cnt_q + (AW + 1)'(do_wr) - (AW + 1)'(do_rd);
        end
    end
endmodule
`default_nettype wire

// File: core/bil_pkg.sv
package bil_pkg;
    // boot source encodings on the strap pins
    localparam logic [1:0] MODE_SPI = 2'h0;
    localparam logic [1:0] MODE_LINK = 2'h1;
    localparam logic [1:0] MODE_OTP = 2'h2;
    localparam logic [1:0] MODE_NONE = 2'h3;
    // timing
    localparam int CORE_CLK_MHZ = 100;
    localparam int LINK_EN_NS = 2000;
    localparam int LINK_EN_CYC = (LINK_EN_NS * CORE_CLK_MHZ) / 1000;
    localparam int TX_HALF_CYC = 8;
    localparam int SETTLE_CYC = 4;
    // channel protocol values and the one-time memory start address
    localparam logic [31:0] ACK_NULL = 32'h0000_FF02;
    localparam logic [7:0] END_TOKEN = 8'h01;
    localparam int OTP_START_ADDR = 0;
    // reset values, pull bit indices and link symbol width
    localparam logic [6:0] PINS_RST = 7'h10;
    localparam logic [1:0] PULL_RST = 2'h3;
    localparam int PULL_SPI = 0;
    localparam int PULL_LINK = 1;
    localparam int SYM_BITS = 9;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_LWAIT = 3'h1,
        ST_ACKW = 3'h3,
        ST_RECV = 3'h2,
        ST_SEND = 3'h6,
        ST_DONE = 3'h7
    } bil_state_e;

    typedef struct packed {
        logic [1:0] boot_mode;
        logic ss_n;
        logic sclk;
        logic mosi;
        logic lrx_clk;
        logic lrx_data;
    } bil_pins_s;

    typedef struct packed {
        logic ctrl;
        logic [7:0] data;
    } bil_sym_s;
endpackage

// File: dv/bil_boot_loader_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module bil_boot_loader_tb_top;
    logic core_clk = 1'b0, rst_n = 1'b0, spi_ss_n = 1'b1, spi_sclk = 1'b0, spi_mosi = 1'b0;
    logic pull_sw_we = 1'b0, img_ready = 1'b0, otp_rvalid = 1'b0;
    logic [1:0] boot_mode = 2'h3, pull_sw_val = 2'h0;
    logic [7:0] otp_rdata = 8'h00;
    wire logic link_rx_clk, link_rx_data;
    logic link_tx_clk, link_tx_data, link_tx_oe, link_en, spi_pin_en, otp_rd_en, img_valid;
    logic boot_busy, chanend0_alloc, jump, overflow;
    logic [1:0] weak_pull_resistor_en, boot_src;
    logic [11:0] otp_addr;
    logic [7:0] img_data;
    int failures = 0, comparisons = 0;
    always #5 core_clk = ~core_clk;
    bil_boot_loader #(.OTP_IMG_BYTES(4)) i_dut (.core_clk, .rst_n, .boot_mode, .spi_ss_n,
        .spi_sclk, .spi_mosi, .link_rx_clk, .link_rx_data, .link_tx_clk, .link_tx_data,
        .link_tx_oe, .link_en, .spi_pin_en, .weak_pull_resistor_en, .pull_sw_we, .pull_sw_val,
        .otp_rd_en, .otp_addr, .otp_rdata, .otp_rvalid, .img_valid, .img_data, .img_ready,
        .boot_src, .boot_busy, .chanend0_alloc, .jump, .overflow);
    bil_link_peer i_peer (.core_clk, .link_tx_clk, .link_tx_data, .link_rx_clk, .link_rx_data);
    // one-time memory: one cycle latency, byte = 0x50 + address, bus toggles when idle
    always @(negedge core_clk) begin
        otp_rvalid <= otp_rd_en;
        otp_rdata <= otp_rd_en ? 8'h50 + otp_addr[7:0] : ~otp_rdata;
    end
    task automatic complete_run();
        $display("failures=%0d comparisons=%0d", failures, comparisons);
        if (failures == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t: %s", $time, m);
        end
    endtask
    // bounded wait for a design flag; running out ends the run
    task automatic wait_hi(ref logic s, output int n);
        n = 0;
        do begin
            @(negedge core_clk);
            n++;
        end while (s !== 1'b1 && n < 3000);
        if (n >= 3000) begin
            failures++;
            $display("unexpected at %0t: wait ran out", $time);
            complete_run();
        end
    endtask
    task automatic boot(input logic [1:0] mode);
        @(negedge core_clk);
        rst_n = 1'b0;
        boot_mode = mode;
        i_peer.got.delete();
        repeat (10) @(negedge core_clk);
        chk(weak_pull_resistor_en, 2'h3, "reset pulls");
        chk({boot_src, link_en, spi_pin_en, jump}, 5'h18, "reset outputs");
        rst_n = 1'b1;
    endtask
    task automatic take(input logic [7:0] exp);
        int n;
        wait_hi(img_valid, n);
        chk(img_data, exp, "image byte");
        img_ready = 1'b1;
        @(negedge core_clk);
        img_ready = 1'b0;
    endtask
    task automatic done_chk();
        int n;
        wait_hi(jump, n);
        @(negedge core_clk);
        chk(jump, 0, "single jump");
        @(negedge core_clk);
        chk(boot_busy, 0, "boot finished");
    endtask
    function automatic logic [7:0] pat(input int i);
        return 8'(i * 37 + 1);
    endfunction
    // nine bytes into an eight deep buffer with the sink stalled; with cpol 1 sclk rises while deselected
    task automatic test_spi(input logic cpol);
        int n;
        logic [7:0] pv;
        boot(bil_pkg::MODE_SPI);
        spi_sclk = cpol;
        wait_hi(spi_pin_en, n);
        @(negedge core_clk);
        chk(weak_pull_resistor_en[0], 0, "serial pull");
        chk(boot_src, bil_pkg::MODE_SPI, "source");
        spi_ss_n = 1'b0;
        repeat (6) @(negedge core_clk);
        for (int i = 0; i < 9; i++) begin
            pv = pat(i);
            for (int b = 0; b < 8; b++) begin
                spi_sclk = 1'b0;
                spi_mosi = pv[b];
                repeat (6) @(negedge core_clk);
                spi_sclk = 1'b1;
                repeat (6) @(negedge core_clk);
            end
        end
        spi_sclk = cpol;
        repeat (6) @(negedge core_clk);
        spi_ss_n = 1'b1;
        chk(overflow, 1, "full buffer drop");
        for (int i = 0; i < 8; i++) take(pat(i));
        done_chk();
    endtask
    task automatic test_link(input logic [31:0] ack);
        int n;
        boot(bil_pkg::MODE_LINK);
        wait_hi(link_en, n);
        chk(n >= 200 && n <= 220, 1, "link enable delay");
        chk(link_tx_data, 0, "tx idle low");
        boot_mode = bil_pkg::MODE_OTP;
        @(negedge core_clk);
        chk({link_tx_oe, weak_pull_resistor_en[1], chanend0_alloc}, 3'h5, "link start");
        for (int i = 3; i >= 0; i--) i_peer.send(1'b0, ack[8*i +: 8]);
        i_peer.send(1'b0, 8'hC3);
        i_peer.send(1'b1, 8'h05);
        i_peer.send(1'b0, 8'h3C);
        i_peer.send(1'b1, bil_pkg::END_TOKEN);
        take(8'hC3);
        take(8'h3C);
        done_chk();
        chk(boot_src, bil_pkg::MODE_LINK, "source held");
        chk(chanend0_alloc, 0, "channel freed");
        if (ack == bil_pkg::ACK_NULL) begin
            chk(i_peer.got.size(), 0, "ack sent");
        end else begin
            chk(i_peer.got.size(), 4, "ack count");
            for (int i = 0; i < 3; i++) chk(i_peer.got[i], {1'b0, ack[31-8*i -: 8]}, "hdr");
            chk(i_peer.got[3], {1'b1, bil_pkg::END_TOKEN}, "end token");
        end
    endtask
    task automatic test_otp();
        boot(bil_pkg::MODE_OTP);
        for (int i = 0; i < 4; i++) take(8'h50 + 8'(i));
        done_chk();
        pull_sw_val = 2'h2;
        pull_sw_we = 1'b1;
        @(negedge core_clk);
        pull_sw_we = 1'b0;
        @(negedge core_clk);
        chk(weak_pull_resistor_en, 2'h2, "software pulls");
    endtask
    // strap left at none: no source is latched and nothing is enabled
    task automatic test_none();
        boot(bil_pkg::MODE_NONE);
        repeat (20) @(negedge core_clk);
        chk({boot_src, boot_busy, spi_pin_en, link_en}, 5'h18, "no source");
    endtask
    initial begin
        test_none();
        test_spi(1'b0);
        test_spi(1'b1);
        test_link(32'h1234_5678);
        test_link(bil_pkg::ACK_NULL);
        test_otp();
        complete_run();
    end
endmodule
`default_nettype wire

// File: dv/bil_link_peer.sv
`timescale 1ns/1ps
`default_nettype none
// far link device: sends symbols on request, collects what the loader sends back
module bil_link_peer (
    input wire logic core_clk, // tile clock, paces the bits
    input wire logic link_tx_clk, // loader transmit clock
    input wire logic link_tx_data, // loader transmit data
    output logic link_rx_clk, // clock into the loader
    output logic link_rx_data // data into the loader
);
    logic [8:0] sh_q = 9'h000;
    int nbit = 0;
    logic [8:0] got[$];
    // wires held low until traffic; the clock stands still between symbols
    initial begin
        link_rx_clk = 1'b0;
        link_rx_data = 1'b0;
    end
    // eight data bits lsb first, then the control flag, 160 ns a bit
    task automatic send(input logic ctrl, input logic [7:0] data);
        logic [8:0] s;
        s = {ctrl, data};
        for (int i = 0; i < 9; i++) begin
            link_rx_data = s[i];
            repeat (8) @(negedge core_clk);
            link_rx_clk = 1'b1;
            repeat (8) @(negedge core_clk);
            link_rx_clk = 1'b0;
        end
        // a cycle later no stale bit is left; an END leaves it low for the next enable
        @(negedge core_clk);
        link_rx_data = ~s[8];
    endtask
    // loader symbols captured on its clock rise
    always @(posedge link_tx_clk) begin
        sh_q = {link_tx_data, sh_q[8:1]};
        nbit = nbit + 1;
        if (nbit == 9) begin
            got.push_back(sh_q);
            nbit = 0;
        end
    end
endmodule
`default_nettype wire
